// *** logic/eitc_top.sv ***
// External interrupt trigger configuration: registers, filter, detection
//
// What this block does
// (R1) Method 000 requests while the pin is low, 001 while it is high.
// (R2) Method 01x detects falling, 10x rising, 11x both edges.
// (R3) Level requests count only after the level held 40 ns.
// (R4) Software picks level or edge and polarity per input.
// (R5) Low word: one 3-bit method per nibble, inputs 0 to 7.
// (R6) Middle word: one 3-bit method per nibble, inputs 8 to 15.
// (R7) Nibble top bit enables the filter for inputs 8 to 23.
// (R8) All three configuration words clear to zero at reset.
// (R9) Each pin is synchronised before filtering and edge detection.
`timescale 1ns/10ps
module eitc_top
	import eitc_pkg::*;
#(
	parameter int NUM_IN = EITC_MAX_IN,
	parameter int FILT_CYC = EITC_FILT_CYC
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// External request pins
	input wire logic [NUM_IN-1:0] ext_request_pin,
	// Register port
	input wire logic [31:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Requests toward the interrupt logic
	output logic [NUM_IN-1:0] req_out
);

	if (NUM_IN < 1 || NUM_IN > EITC_MAX_IN) begin : g_chk
		$error("eitc_top: NUM_IN must be between 1 and 24");
	end

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [2:0] meth_of(input logic [EITC_ALL_W-1:0] all,
		input int idx);
		meth_of = all[idx * EITC_NIB +: EITC_METH_W];
	endfunction

	function automatic eitc_trig_t trig_of(input logic [2:0] m);
		eitc_trig_t t;
		t = EITC_TRIG_LOW;
		case (m[2:1])
			EITC_E_LEVEL: t = (m == EITC_M_HIGH) ? EITC_TRIG_HIGH :
				EITC_TRIG_LOW;
			EITC_E_FALL: t = EITC_TRIG_FALL;
			EITC_E_RISE: t = EITC_TRIG_RISE;
			default: t = EITC_TRIG_BOTH;
		endcase
		trig_of = t;
	endfunction

	function automatic logic flt_on(input logic [EITC_ALL_W-1:0] all,
		input int idx);
		// The first eight inputs have no enable and are always filtered
		if (idx < EITC_PER_REG) begin
			flt_on = 1'b1;
		end else begin
			flt_on = all[idx * EITC_NIB + EITC_FLT_BIT];
		end
	endfunction

	// ****************************************************************
	// Configuration registers
	// ****************************************************************
	logic [31:0] cfg_low_r;
	logic [31:0] cfg_mid_r;
	logic [31:0] cfg_high_r;
	logic [EITC_ALL_W-1:0] cfg_all;

	assign cfg_all = {cfg_high_r, cfg_mid_r, cfg_low_r};

	// (R8) Reset to zero
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			cfg_low_r <= EITC_CFG_RESET;
			cfg_mid_r <= EITC_CFG_RESET;
			cfg_high_r <= EITC_CFG_RESET;
		end else if (reg_wr) begin
			// (R5) (R6) (R4) Method fields per nibble
			if (reg_addr == EITC_CFG_LOW_ADDR) begin
				cfg_low_r <= reg_wdata & EITC_LOW_MASK;
			end else if (reg_addr == EITC_CFG_MID_ADDR) begin
				cfg_mid_r <= reg_wdata;
			end else if (reg_addr == EITC_CFG_HIGH_ADDR) begin
				cfg_high_r <= reg_wdata;
			end
		end
	end

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [NUM_IN-1:0] sync1_r;
	logic [NUM_IN-1:0] sync2_r;

	// (R9) Two-stage synchroniser
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= ext_request_pin;
			sync2_r <= sync1_r;
		end
	end

	// ****************************************************************
	// Noise filter
	// ****************************************************************
	eitc_filt_if #(.N(NUM_IN)) fbus ();
	logic [NUM_IN-1:0] flt_en;

	// (R7) Filter enables from the nibble top bits
	always_comb begin
		for (int i = 0; i < NUM_IN; i++) begin
			flt_en[i] = flt_on(cfg_all, i);
		end
	end

	assign fbus.raw = sync2_r;
	assign fbus.en = flt_en;

	// (R3) Level must persist FILT_CYC samples
	eitc_filter #(
		.N(NUM_IN),
		.CYC(FILT_CYC)
	) u_filter (
		.ref_clk(ref_clk),
		.reset(reset),
		.fi(fbus.filt_side)
	);

	// ****************************************************************
	// Trigger detection
	// ****************************************************************
	logic [NUM_IN-1:0] filt;
	logic [NUM_IN-1:0] prev_r;
	logic [NUM_IN-1:0] req_r;
	logic [NUM_IN-1:0] req_nxt;

	assign filt = fbus.filt;

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			prev_r <= '0;
		end else begin
			prev_r <= filt;
		end
	end

	// (R1) (R2) Level or edge per method code
	always_comb begin
		for (int i = 0; i < NUM_IN; i++) begin
			case (trig_of(meth_of(cfg_all, i)))
				EITC_TRIG_LOW: req_nxt[i] = !filt[i];
				EITC_TRIG_HIGH: req_nxt[i] = filt[i];
				EITC_TRIG_FALL: req_nxt[i] = prev_r[i] && !filt[i];
				EITC_TRIG_RISE: req_nxt[i] = !prev_r[i] && filt[i];
				default: req_nxt[i] = prev_r[i] != filt[i];
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			req_r <= '0;
		end else begin
			req_r <= req_nxt;
		end
	end

	assign req_out = req_r;

	// ****************************************************************
	// Register read
	// ****************************************************************
	logic [31:0] rdata_r;
	logic [31:0] status;

	always_comb begin
		status = EITC_RD_NONE;
		status[NUM_IN-1:0] = filt;
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			rdata_r <= EITC_RD_NONE;
		end else if (!reg_rd) begin
			rdata_r <= EITC_RD_NONE;
		end else if (reg_addr == EITC_CFG_LOW_ADDR) begin
			rdata_r <= cfg_low_r;
		end else if (reg_addr == EITC_CFG_MID_ADDR) begin
			rdata_r <= cfg_mid_r;
		end else if (reg_addr == EITC_CFG_HIGH_ADDR) begin
			rdata_r <= cfg_high_r;
		end else if (reg_addr == EITC_STATUS_ADDR) begin
			rdata_r <= status;
		end else begin
			rdata_r <= EITC_RD_NONE;
		end
	end

	assign reg_rdata = rdata_r;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	logic [2:0] m0;
	assign m0 = meth_of(cfg_all, 0);

	low_level_a: // (R1)
	assert property (@(posedge ref_clk) disable iff (reset)
		(m0 == EITC_M_LOW) |=> (req_out[0] == !$past(filt[0])))
	else $error("low level method did not follow the pin");

	high_level_a: // (R1)
	assert property (@(posedge ref_clk) disable iff (reset)
		(m0 == EITC_M_HIGH) |=> (req_out[0] == $past(filt[0])))
	else $error("high level method did not follow the pin");

	fall_edge_a: // (R2)
	assert property (@(posedge ref_clk) disable iff (reset)
		(m0[2:1] == EITC_E_FALL && $fell(filt[0])) |=> req_out[0])
	else $error("falling edge missed");

	rise_edge_a: // (R2)
	assert property (@(posedge ref_clk) disable iff (reset)
		(m0[2:1] == EITC_E_RISE && $fell(filt[0])) |=> !req_out[0])
	else $error("rising method fired on a falling edge");

	both_edge_a: // (R2)
	assert property (@(posedge ref_clk) disable iff (reset)
		(m0[2:1] == EITC_E_BOTH) |=>
		(req_out[0] == $past(prev_r[0] != filt[0])))
	else $error("both edge method wrong");

	edge_pulse_a: // (R2)
	assert property (@(posedge ref_clk) disable iff (reset)
		(m0[2:1] != EITC_E_LEVEL && $stable(filt[0])) |=> !req_out[0])
	else $error("edge request without an edge");

	filt_hold_a: // (R3)
	assert property (@(posedge ref_clk) disable iff (reset)
		$rose(filt[0]) |-> ($past(sync2_r[0], 1) && $past(sync2_r[0], 2) &&
		$past(sync2_r[0], 3) && $past(sync2_r[0], 4)))
	else $error("filtered level changed before 40 ns");

	low_read_a: // (R5)
	assert property (@(posedge ref_clk) disable iff (reset)
		(reg_rd && reg_addr == EITC_CFG_LOW_ADDR) |=>
		(reg_rdata == $past(cfg_low_r) && (reg_rdata & ~EITC_LOW_MASK) == '0))
	else $error("low word read wrong");

	mid_write_a: // (R6) (R4)
	assert property (@(posedge ref_clk) disable iff (reset)
		(reg_wr && reg_addr == EITC_CFG_MID_ADDR) |=>
		(cfg_mid_r == $past(reg_wdata)))
	else $error("middle word write lost");

	high_write_a: // (R4)
	assert property (@(posedge ref_clk) disable iff (reset)
		(reg_wr && reg_addr == EITC_CFG_HIGH_ADDR) |=>
		(cfg_high_r == $past(reg_wdata)))
	else $error("high word write lost");

	rd_idle_a: // (R4)
	assert property (@(posedge ref_clk) disable iff (reset)
		!reg_rd |=> (reg_rdata == EITC_RD_NONE))
	else $error("read data shown without a read strobe");

	cfg_reset_a: // (R8)
	assert property (@(posedge ref_clk) disable iff (reset)
		$fell(reset) |-> (cfg_all == '0))
	else $error("configuration not zero after reset");

	sync_delay_a: // (R9)
	assert property (@(posedge ref_clk) disable iff (reset)
		##2 (sync2_r == $past(ext_request_pin, 2)))
	else $error("synchroniser delay is not two cycles");

	if (NUM_IN > EITC_PER_REG) begin : g_byp
		bypass_a: // (R7)
		assert property (@(posedge ref_clk) disable iff (reset)
			!cfg_mid_r[EITC_FLT_BIT] |=>
			(filt[EITC_PER_REG] == $past(sync2_r[EITC_PER_REG])))
		else $error("disabled filter did not pass the level");
	end

	cov_low_c: cover property (@(posedge ref_clk) disable iff (reset)
		m0 == EITC_M_LOW && req_out[0]);
	cov_rise_c: cover property (@(posedge ref_clk) disable iff (reset)
		m0[2:1] == EITC_E_RISE ##1 req_out[0]);
	cov_both_c: cover property (@(posedge ref_clk) disable iff (reset)
		m0[2:1] == EITC_E_BOTH && $fell(filt[0]) ##1 req_out[0]);
	cov_read_c: cover property (@(posedge ref_clk) disable iff (reset)
		reg_rd && reg_addr == EITC_STATUS_ADDR);

endmodule

// *** logic/eitc_pkg.sv ***
// Constants and types shared by the external trigger configuration block
package eitc_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [31:0] EITC_CFG_LOW_ADDR = 32'h5600_0088;
	localparam logic [31:0] EITC_CFG_MID_ADDR = 32'h5600_008C;
	localparam logic [31:0] EITC_CFG_HIGH_ADDR = 32'h5600_0090;
	localparam logic [31:0] EITC_STATUS_ADDR = 32'h5600_00B0;
	localparam logic [31:0] EITC_CFG_RESET = 32'h0000_0000;
	localparam logic [31:0] EITC_RD_NONE = 32'h0000_0000;
	// The low word has no filter enables, so those bits read as zero
	localparam logic [31:0] EITC_LOW_MASK = 32'h7777_7777;

	// ****************************************************************
	// Field layout
	// ****************************************************************
	localparam int EITC_MAX_IN = 24;
	localparam int EITC_PER_REG = 8;
	localparam int EITC_NIB = 4;
	localparam int EITC_METH_W = 3;
	localparam int EITC_FLT_BIT = 3;
	localparam int EITC_ALL_W = 96;

	// ****************************************************************
	// Method codes
	// ****************************************************************
	localparam logic [2:0] EITC_M_LOW = 3'h0;
	localparam logic [2:0] EITC_M_HIGH = 3'h1;
	localparam logic [1:0] EITC_E_LEVEL = 2'h0;
	localparam logic [1:0] EITC_E_FALL = 2'h1;
	localparam logic [1:0] EITC_E_RISE = 2'h2;
	localparam logic [1:0] EITC_E_BOTH = 2'h3;

	typedef enum logic [2:0] {
		EITC_TRIG_LOW,
		EITC_TRIG_HIGH,
		EITC_TRIG_FALL,
		EITC_TRIG_RISE,
		EITC_TRIG_BOTH
	} eitc_trig_t;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int EITC_CLK_NS = 10;
	localparam int EITC_FILT_NS = 40;
	localparam int EITC_FILT_RAW = (EITC_FILT_NS + EITC_CLK_NS - 1) / EITC_CLK_NS;
	localparam int EITC_FILT_CYC = (EITC_FILT_RAW < 1) ? 1 : EITC_FILT_RAW;

endpackage

// *** logic/eitc_filt_if.sv ***
// Carrier between the trigger logic and the noise filter
`timescale 1ns/10ps
interface eitc_filt_if #(
	parameter int N = 24
);
	logic [N-1:0] raw;
	logic [N-1:0] en;
	logic [N-1:0] filt;

	modport filt_side (
		input raw,
		input en,
		output filt
	);
	modport user_side (
		output raw,
		output en,
		input filt
	);
endinterface

// *** logic/eitc_filter.sv ***
// Per-input noise filter with bypass
`timescale 1ns/10ps
module eitc_filter
	import eitc_pkg::*;
#(
	parameter int N = 24,
	parameter int CYC = EITC_FILT_CYC
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Raw levels in, filtered levels out
	eitc_filt_if.filt_side fi
);

	localparam int CW = $clog2(CYC + 1);
	localparam logic [CW-1:0] CNT_LAST = CW'(CYC - 1);
	localparam logic [CW-1:0] CNT_ZERO = '0;

	if (CYC < 1 || N < 1) begin : g_chk
		$error("eitc_filter: CYC and N must be at least one");
	end

	logic [CW-1:0] cnt_r [N];
	logic [N-1:0] out_r;

	assign fi.filt = out_r;

	// ****************************************************************
	// Stability counters
	// ****************************************************************
	// When enabled, a new level is passed on only after CYC differing samples in a row
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			out_r <= '0;
			for (int i = 0; i < N; i++) begin
				cnt_r[i] <= CNT_ZERO;
			end
		end else begin
			for (int i = 0; i < N; i++) begin
				if (!fi.en[i]) begin
					out_r[i] <= fi.raw[i];
					cnt_r[i] <= CNT_ZERO;
				end else if (fi.raw[i] == out_r[i]) begin
					cnt_r[i] <= CNT_ZERO;
				end else if (cnt_r[i] == CNT_LAST) begin
					out_r[i] <= fi.raw[i];
					cnt_r[i] <= CNT_ZERO;
				end else begin
					cnt_r[i] <= CW'(cnt_r[i] + 1'b1);
				end
			end
		end
	end

endmodule

// *** sim/eitc_pin_src.sv ***
// Model of the external sources that drive the request pins
`timescale 1ns/10ps
module eitc_pin_src (
	// Wanted levels and short-pulse mask from the bench
	input wire logic [23:0] lvl,
	input wire logic [23:0] flip,
	// Pins toward the block
	output logic [23:0] ext_request_pin
);
	// ****************************************************************
	// Pin drive
	// ****************************************************************
	// Held levels and flips
	// Levels are held as long as the bench asks; a flip mask held for
	// fewer than four cycles makes a pulse the filter must reject
	assign ext_request_pin = lvl ^ flip;
endmodule

// *** sim/test_external_irq_trigger_config.sv ***
// Self-checking bench for the external trigger configuration block
`timescale 1ns/10ps
module test_external_irq_trigger_config;
	import eitc_pkg::*;
	logic ref_clk;
	logic reset;
	logic [23:0] lvl;
	logic [23:0] flip;
	logic [23:0] ext_request_pin;
	logic [31:0] reg_addr;
	logic [31:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [31:0] reg_rdata;
	logic [23:0] req_out;
	int n_mismatch;
	int samples_checked;
	int k;

	eitc_pin_src i_src (
		.lvl(lvl),
		.flip(flip),
		.ext_request_pin(ext_request_pin)
	);
	eitc_top #(.NUM_IN(24), .FILT_CYC(4)) i_dut (
		.ref_clk(ref_clk),
		.reset(reset),
		.ext_request_pin(ext_request_pin),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.req_out(req_out)
	);

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			n_mismatch++;
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [31:0] a, input logic [31:0] exp);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask
	task automatic pin(input int i, input logic v);
		@(posedge ref_clk);
		lvl[i] <= v;
	endtask
	// Output must still be old d edges after the pin change, new one later
	task automatic lat(input int i, input logic v, input int d);
		pin(i, v);
		repeat (d) @(posedge ref_clk);
		#1;
		chk(32'(req_out[i]), 32'(!v));
		@(posedge ref_clk);
		#1;
		chk(32'(req_out[i]), 32'(v));
	endtask
	task automatic glitch(input int i, input int n);
		@(posedge ref_clk);
		flip[i] <= 1'b1;
		repeat (n) @(posedge ref_clk);
		flip[i] <= 1'b0;
	endtask
	task automatic hcount(input logic [23:0] m, input int n);
		k = 0;
		repeat (n) begin
			@(posedge ref_clk);
			#1;
			// An unknown counts as a request, so it cannot slip through
			if ((req_out & m) !== '0) k++;
		end
	endtask

	// Run is a few hundred cycles; this cuts a hang short
	initial begin
		#50000;
		n_mismatch++;
		test_done();
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		lvl = '0;
		flip = '0;
		reg_addr = '0;
		reg_wdata = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reset = 1'b1;
		n_mismatch = 0;
		samples_checked = 0;
		repeat (10) @(posedge ref_clk);
		reset <= 1'b0;
		repeat (3) @(posedge ref_clk);
		#1;
		chk(32'(req_out), 32'h00FF_FFFF);
		rd(EITC_CFG_LOW_ADDR, EITC_CFG_RESET);
		rd(EITC_CFG_MID_ADDR, EITC_CFG_RESET);
		rd(EITC_CFG_HIGH_ADDR, EITC_CFG_RESET);
		wr(EITC_CFG_LOW_ADDR, 32'hFFFF_FFFF);
		rd(EITC_CFG_LOW_ADDR, 32'h7777_7777);
		wr(EITC_CFG_MID_ADDR, 32'hFFFF_FFFF);
		rd(EITC_CFG_MID_ADDR, 32'hFFFF_FFFF);
		wr(EITC_CFG_HIGH_ADDR, 32'hA5A5_A5A5);
		rd(EITC_CFG_HIGH_ADDR, 32'hA5A5_A5A5);
		// Unmapped place must neither store nor disturb neighbours
		wr(32'h5600_0084, 32'h1234_5678);
		rd(32'h5600_0084, EITC_RD_NONE);
		rd(EITC_CFG_MID_ADDR, 32'hFFFF_FFFF);
		wr(EITC_CFG_HIGH_ADDR, 32'h0000_0000);
		$display("test registers done");

		// Inputs 0 and 7 high level, the rest low level
		wr(EITC_CFG_LOW_ADDR, 32'h1000_0001);
		wr(EITC_CFG_MID_ADDR, 32'h0000_0000);
		@(posedge ref_clk);
		lvl[7:0] <= 8'hFF;
		repeat (10) @(posedge ref_clk);
		#1;
		chk(32'(req_out[7:0]), 32'h81);
		@(posedge ref_clk);
		lvl[7:0] <= 8'h00;
		repeat (10) @(posedge ref_clk);
		#1;
		chk(32'(req_out[7:0]), 32'h7E);
		lat(0, 1'b1, 6);
		lat(0, 1'b0, 6);
		glitch(0, 3);
		hcount(24'h00_0001, 12);
		chk(32'(k), 32'h0);
		$display("test level and filter done");

		// Input 8 high level, filter bypassed then enabled
		wr(EITC_CFG_MID_ADDR, 32'h0000_0001);
		repeat (10) @(posedge ref_clk);
		lat(8, 1'b1, 3);
		lat(8, 1'b0, 3);
		glitch(8, 1);
		hcount(24'h00_0100, 12);
		chk(32'(k), 32'h1);
		wr(EITC_CFG_MID_ADDR, 32'h0000_0009);
		glitch(8, 3);
		hcount(24'h00_0100, 12);
		chk(32'(k), 32'h0);
		lat(8, 1'b1, 6);
		lat(8, 1'b0, 6);
		$display("test filter enable done");

		// Every edge code on input 0 (filtered) and input 8 (bypassed);
		// their pulses land in different cycles, so both are counted
		for (int c = 2; c < 8; c++) begin
			wr(EITC_CFG_LOW_ADDR, 32'(c));
			wr(EITC_CFG_MID_ADDR, 32'(c));
			repeat (5) @(posedge ref_clk);
			lvl[0] <= 1'b1;
			lvl[8] <= 1'b1;
			hcount(24'h00_0101, 10);
			chk(32'(k), 32'({c[2], 1'b0}));
			@(posedge ref_clk);
			lvl[0] <= 1'b0;
			lvl[8] <= 1'b0;
			hcount(24'h00_0101, 10);
			chk(32'(k), 32'({c[1], 1'b0}));
		end
		$display("test edge codes done");

		// Top nibbles: input 15 filtered, input 23 bypassed, high level
		wr(EITC_CFG_MID_ADDR, 32'h9000_0000);
		wr(EITC_CFG_HIGH_ADDR, 32'h1000_0000);
		repeat (2) @(posedge ref_clk);
		#1;
		chk(32'(req_out[23]), 32'h0);
		@(posedge ref_clk);
		lvl[15] <= 1'b1;
		lvl[23] <= 1'b1;
		repeat (10) @(posedge ref_clk);
		#1;
		chk(32'(req_out[15]), 32'h1);
		chk(32'(req_out[8]), 32'h1);
		chk(32'(req_out[23]), 32'h1);
		// Status shows the filtered pin levels
		rd(EITC_STATUS_ADDR, 32'h0080_8000);
		$display("test top nibble done");
		test_done();
	end
endmodule
